// file: include/adaptive_eq_pkg.sv
package adaptive_eq_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] ADDR_FILTER_LIMITS = 8'h41;
   localparam logic [7:0] ADDR_ADAPT_CTL     = 8'h42;
   localparam logic [7:0] ADDR_ERR_THOLD     = 8'h43;
   localparam logic [7:0] ADDR_RSVD_A        = 8'h44;
   localparam logic [7:0] ADDR_RSVD_B        = 8'h45;
   localparam logic [7:0] ADDR_PORT_SEL      = 8'h4C;
   localparam logic [7:0] ADDR_ADAPT_STATUS  = 8'h4E;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTL_ERR_SEL_LSB  = 4;
   localparam int CTL_ORDER_BIT    = 3;
   localparam int CTL_TWO_STEP_BIT = 2;
   localparam int CTL_OUTER_BIT    = 1;
   localparam int CTL_FILT_EN_BIT  = 0;
   localparam int PSEL_RD_LSB      = 4;
   localparam int LIMIT_MAX_LSB    = 4;
   localparam int STAT_BUSY_BIT    = 7;
   localparam int STAT_PASS_BIT    = 6;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and masks
   localparam logic [7:0] CTL_RESET      = 8'h71;
   localparam logic [7:0] CTL_WR_MASK    = 8'h7F;
   localparam logic [7:0] THOLD_RESET    = 8'h01;
   localparam logic [3:0] FILT_MAX_RESET = 4'hA;
   localparam logic [3:0] FILT_MIN_RESET = 4'h9;
   localparam logic [7:0] PORT_SEL_RESET = 8'h01;
   localparam logic [7:0] PORT_SEL_MASK  = 8'h3F;

   ////////////////////////////////////////////////////////////////////////////
   // Setting ranges
   localparam logic [3:0] FILT_MID    = 4'h7;
   localparam logic [3:0] FILT_TOP    = 4'hE;
   localparam logic [3:0] EQ_MAX      = 4'hF;
   localparam logic [7:0] ERR_CNT_MAX = 8'hFF;

   // Adaptation sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_NEXT = 2'b10
   } adapt_state_t;

endpackage

// file: src/adaptive_eq_control.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Error checking runs while any bit of the three-bit error select is set.
// - Selected errors are accumulated over the second half of the relock period.
// - Accumulated errors above threshold step to the next equalizer or filter setting.
// - Select bit 2 counts clock errors, bit 1 sequence errors, bit 0 parity.
// - Order bit 0 starts filter at largest delay; 1 starts at midpoint.
// - Two-step clear: wait full period, check lock; set: wait half, count half.
// - In two-step mode any selected error in the second half advances to next setting at once.
// - Outer-loop bit 0: equalizer inner loop; 1: filter inner loop.
// - Filter-adapt enable, set at reset, includes filter stepping in adaptation.
// - Eight-bit read-write error threshold, reset value one.
// - Reads go to port in bits 5:4; writes to each port enabled in 3:0.
// - Filter settings stay 0 to 14, midpoint 7, reset value 0; sweeps stay within programmed limits.
module adaptive_eq_control
   import adaptive_eq_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [7:0]  reg_rdata,
   input  wire logic [15:0] relock_period_setting,
   input  wire logic        adapt_start,
   input  wire logic        link_lock,
   input  wire logic        err_clock_pattern,
   input  wire logic        err_control_channel_sequence,
   input  wire logic        err_parity,
   output var  logic [3:0]  eq_setting,
   output var  logic [3:0]  strobe_filter_setting,
   output var  logic        adapt_busy,
   output var  logic        adapt_done,
   output var  logic        adapt_pass,
   output var  logic [1:0]  port_read_select,
   output var  logic [3:0]  port_write_enable
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      adapt_state_t state;
      logic [7:0]   ctl;
      logic [7:0]   thold;
      logic [3:0]   fmax;
      logic [3:0]   fmin;
      logic [7:0]   psel;
      logic [15:0]  timer;
      logic [7:0]   err_cnt;
      logic [3:0]   eq;
      logic [3:0]   filt;
      logic [3:0]   fsteps;
      logic         busy;
      logic         pass;
      logic         done;
      logic [7:0]   rdata;
   } eq_state_t;

   eq_state_t   s_reg;
   eq_state_t   s_next;
   logic [2:0]  errs;
   logic [1:0]  n_err;
   logic [8:0]  cnt_sum;
   logic [7:0]  cnt_nx;
   logic        counting;
   logic        period_end;
   logic [3:0]  span;
   logic        eq_last;
   logic        filt_last;
   logic        two_step;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // First filter value of a sweep
   function automatic logic [3:0] filt_start(input logic       order,
                                             input logic [3:0] lo,
                                             input logic [3:0] hi);
      logic [3:0] v;
      if (order) begin
         v = FILT_MID;
         if (v < lo) begin
            v = lo;
         end else if (v > hi) begin
            v = hi;
         end
      end else begin
         v = hi;
      end
      return v;
   endfunction

   // Next filter value, wrapping inside the limits
   function automatic logic [3:0] filt_step(input logic       order,
                                            input logic [3:0] cur,
                                            input logic [3:0] lo,
                                            input logic [3:0] hi);
      logic [3:0] v;
      if (order) begin
         v = (cur >= hi) ? lo : cur + 4'h1;
      end else begin
         v = (cur <= lo) ? hi : cur - 4'h1;
      end
      return v;
   endfunction

   // Limit writes to the legal filter range
   function automatic logic [3:0] filt_clip(input logic [3:0] v);
      return (v > FILT_TOP) ? FILT_TOP : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Error accumulation and period timing

   always_comb begin
      errs       = {err_clock_pattern, err_control_channel_sequence, err_parity}
                   & s_reg.ctl[CTL_ERR_SEL_LSB +: 3];
      n_err      = {1'b0, errs[0]} + {1'b0, errs[1]} + {1'b0, errs[2]};
      counting   = (s_reg.state == ST_WAIT)
                   && (s_reg.timer >= (relock_period_setting >> 1));
      cnt_sum    = {1'b0, s_reg.err_cnt} + {7'h00, n_err};
      cnt_nx     = !counting ? s_reg.err_cnt
                   : (cnt_sum[8] ? ERR_CNT_MAX : cnt_sum[7:0]);
      period_end = ({1'b0, s_reg.timer} + 17'h00001)
                   >= {1'b0, relock_period_setting};
      span       = (s_reg.fmax > s_reg.fmin) ? s_reg.fmax - s_reg.fmin : 4'h0;
      eq_last    = (s_reg.eq == EQ_MAX);
      filt_last  = (s_reg.fsteps >= span);
      two_step   = s_reg.ctl[CTL_TWO_STEP_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      s_next       = s_reg;
      s_next.done  = 1'b0;
      s_next.rdata = 8'h00;

      // Register writes
      if (reg_wr) begin
         if (reg_addr == ADDR_FILTER_LIMITS) begin
            s_next.fmax = filt_clip(reg_wdata[LIMIT_MAX_LSB +: 4]);
            s_next.fmin = filt_clip(reg_wdata[3:0]);
         end else if (reg_addr == ADDR_ADAPT_CTL) begin
            s_next.ctl = reg_wdata & CTL_WR_MASK;
         end else if (reg_addr == ADDR_ERR_THOLD) begin
            s_next.thold = reg_wdata;
         end else if (reg_addr == ADDR_PORT_SEL) begin
            s_next.psel = reg_wdata & PORT_SEL_MASK;
         end
      end

      // Register reads, answered next cycle
      if (reg_rd) begin
         if (reg_addr == ADDR_FILTER_LIMITS) begin
            s_next.rdata = {s_reg.fmax, s_reg.fmin};
         end else if (reg_addr == ADDR_ADAPT_CTL) begin
            s_next.rdata = s_reg.ctl;
         end else if (reg_addr == ADDR_ERR_THOLD) begin
            s_next.rdata = s_reg.thold;
         end else if (reg_addr == ADDR_PORT_SEL) begin
            s_next.rdata = s_reg.psel;
         end else if (reg_addr == ADDR_ADAPT_STATUS) begin
            s_next.rdata = {s_reg.busy, s_reg.pass, 2'b00, s_reg.eq};
         end else begin
            s_next.rdata = 8'h00;
         end
      end

      // Adaptation sequencer
      case (s_reg.state)
         ST_IDLE: begin
            if (adapt_start) begin
               s_next.state   = ST_WAIT;
               s_next.busy    = 1'b1;
               s_next.pass    = 1'b0;
               s_next.eq      = 4'h0;
               s_next.filt    = filt_start(s_reg.ctl[CTL_ORDER_BIT],
                                           s_reg.fmin, s_reg.fmax);
               s_next.fsteps  = 4'h0;
               s_next.timer   = 16'h0000;
               s_next.err_cnt = 8'h00;
            end
         end
         ST_WAIT: begin
            s_next.timer   = s_reg.timer + 16'h0001;
            s_next.err_cnt = cnt_nx;
            if (two_step && counting && (n_err != 2'b00)) begin
               s_next.state = ST_NEXT;
            end else if (period_end) begin
               if (cnt_nx > s_reg.thold) begin
                  s_next.state = ST_NEXT;
               end else if (!two_step && !link_lock) begin
                  s_next.state = ST_NEXT;
               end else begin
                  s_next.state = ST_IDLE;
                  s_next.busy  = 1'b0;
                  s_next.pass  = 1'b1;
                  s_next.done  = 1'b1;
               end
            end
         end
         ST_NEXT: begin
            s_next.state   = ST_WAIT;
            s_next.timer   = 16'h0000;
            s_next.err_cnt = 8'h00;
            if (!s_reg.ctl[CTL_FILT_EN_BIT]) begin
               if (eq_last) begin
                  s_next.state = ST_IDLE;
               end else begin
                  s_next.eq = s_reg.eq + 4'h1;
               end
            end else if (!s_reg.ctl[CTL_OUTER_BIT]) begin
               // Equalizer inner, filter outer
               if (!eq_last) begin
                  s_next.eq = s_reg.eq + 4'h1;
               end else if (!filt_last) begin
                  s_next.eq     = 4'h0;
                  s_next.filt   = filt_step(s_reg.ctl[CTL_ORDER_BIT], s_reg.filt,
                                            s_reg.fmin, s_reg.fmax);
                  s_next.fsteps = s_reg.fsteps + 4'h1;
               end else begin
                  s_next.state = ST_IDLE;
               end
            end else begin
               // Filter inner, equalizer outer
               if (!filt_last) begin
                  s_next.filt   = filt_step(s_reg.ctl[CTL_ORDER_BIT], s_reg.filt,
                                            s_reg.fmin, s_reg.fmax);
                  s_next.fsteps = s_reg.fsteps + 4'h1;
               end else if (!eq_last) begin
                  s_next.eq     = s_reg.eq + 4'h1;
                  s_next.filt   = filt_start(s_reg.ctl[CTL_ORDER_BIT],
                                             s_reg.fmin, s_reg.fmax);
                  s_next.fsteps = 4'h0;
               end else begin
                  s_next.state = ST_IDLE;
               end
            end
            if (s_next.state == ST_IDLE) begin
               s_next.busy = 1'b0;                                       // Sweep exhausted
               s_next.done = 1'b1;
            end
         end
         default: begin
            s_next.state = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_reg         <= '0;
         s_reg.state   <= ST_IDLE;
         s_reg.ctl     <= CTL_RESET;
         s_reg.thold   <= THOLD_RESET;
         s_reg.fmax    <= FILT_MAX_RESET;
         s_reg.fmin    <= FILT_MIN_RESET;
         s_reg.psel    <= PORT_SEL_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata             = s_reg.rdata;
   assign eq_setting            = s_reg.eq;
   assign strobe_filter_setting = s_reg.filt;
   assign adapt_busy            = s_reg.busy;
   assign adapt_done            = s_reg.done;
   assign adapt_pass            = s_reg.pass;
   assign port_read_select      = s_reg.psel[PSEL_RD_LSB +: 2];
   assign port_write_enable     = s_reg.psel[3:0];

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   AST_ERR_DISABLED: assert property (
      (s_reg.state == ST_WAIT && s_reg.ctl[CTL_ERR_SEL_LSB +: 3] == 3'b000)
      |=> s_reg.err_cnt == $past(s_reg.err_cnt))
      else $error("error count moved with no error type selected");
   AST_PARITY_COUNT: assert property (
      (counting && !two_step && s_reg.ctl[CTL_ERR_SEL_LSB +: 3] == 3'b001
       && err_parity && s_reg.err_cnt < ERR_CNT_MAX)
      |=> s_reg.err_cnt == $past(s_reg.err_cnt) + 8'h01)
      else $error("parity error not counted");
   AST_FIRST_HALF_QUIET: assert property (
      (s_reg.state == ST_WAIT && !counting) |=> s_reg.err_cnt == $past(s_reg.err_cnt))
      else $error("errors counted in first half period");
   AST_THRESHOLD_STEP: assert property (
      (s_reg.state == ST_WAIT && period_end && cnt_nx > s_reg.thold)
      |=> s_reg.state == ST_NEXT ##1 s_reg.state != ST_NEXT)
      else $error("threshold exceeded without stepping");
   AST_START_ORDER: assert property (
      (s_reg.state == ST_IDLE && adapt_start && !s_reg.ctl[CTL_ORDER_BIT])
      |=> s_reg.filt == $past(s_reg.fmax) && s_reg.eq == 4'h0)
      else $error("filter sweep did not start at largest delay");
   AST_LOCK_CHECK: assert property (
      (s_reg.state == ST_WAIT && period_end && !two_step && !link_lock)
      |=> s_reg.state == ST_NEXT)
      else $error("loss of lock accepted as valid setting");
   AST_TWO_STEP_EARLY: assert property (
      (two_step && counting && n_err != 2'b00) |=> s_reg.state == ST_NEXT)
      else $error("two-step error did not advance at once");
   AST_EQ_INNER: assert property (
      (s_reg.state == ST_NEXT && s_reg.ctl[CTL_FILT_EN_BIT]
       && !s_reg.ctl[CTL_OUTER_BIT] && !eq_last)
      |=> s_reg.eq == $past(s_reg.eq) + 4'h1 && $stable(s_reg.filt))
      else $error("equalizer not stepped as inner loop");
   AST_NO_FILTER: assert property (
      (s_reg.state == ST_NEXT && !s_reg.ctl[CTL_FILT_EN_BIT]) |=> $stable(s_reg.filt))
      else $error("filter stepped while filter adaptation off");
   AST_PORT_SELECT: assert property (
      (reg_wr && reg_addr == ADDR_PORT_SEL)
      |=> port_write_enable == $past(reg_wdata[3:0])
          && port_read_select == $past(reg_wdata[5:4]))
      else $error("port select not applied");
   AST_FILTER_RANGE: assert property (s_reg.filt <= FILT_TOP)
      else $error("filter setting out of range");
   COV_PASS: cover property (s_reg.state == ST_WAIT ##1 adapt_done && adapt_pass);
   COV_TWO_STEP: cover property (two_step && counting && n_err != 2'b00);
   COV_FILTER_STEP: cover property (s_reg.state == ST_NEXT ##1 $changed(s_reg.filt));
   COV_EXHAUST: cover property (adapt_done && !adapt_pass);

endmodule

`default_nettype wire

// file: verification/adaptive_eq_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module adaptive_eq_control_tb;
   import adaptive_eq_pkg::*;

   logic        clk, sys_rst, reg_wr, reg_rd, adapt_start, lock_ok;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [15:0] period;
   logic [2:0]  inject;
   logic        link_lock, e_clk, e_seq, e_par, adapt_busy, adapt_done, adapt_pass;
   logic [3:0]  eq_setting, filt, port_write_enable, eq_mid, filt_mid;
   logic [1:0]  port_read_select;
   int          failures, tests_run, n;
   logic [7:0]  rst_addr [8] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h4C, 8'h4E, 8'h50};
   logic [7:0]  rst_val  [8] = '{8'hA9, 8'h71, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
   logic [7:0]  mode     [4] = '{8'h71, 8'h73, 8'h7B, 8'h70};
   logic [3:0]  fst      [4] = '{4'hC, 4'hC, 4'h7, 4'hF};
   logic [3:0]  eqm      [4] = '{4'h1, 4'h0, 4'h0, 4'h1};
   logic [3:0]  flm      [4] = '{4'hC, 4'hB, 4'h8, 4'hF};

   adaptive_eq_control i_dut (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .relock_period_setting(period), .adapt_start(adapt_start), .link_lock(link_lock),
      .err_clock_pattern(e_clk), .err_control_channel_sequence(e_seq), .err_parity(e_par),
      .eq_setting(eq_setting), .strobe_filter_setting(filt), .adapt_busy(adapt_busy),
      .adapt_done(adapt_done), .adapt_pass(adapt_pass),
      .port_read_select(port_read_select), .port_write_enable(port_write_enable)
   );

   remote_serializer_model i_far (
      .clk(clk), .sys_rst(sys_rst), .inject(inject), .lock_ok(lock_ok), .link_lock(link_lock),
      .err_clock_pattern(e_clk), .err_control_channel_sequence(e_seq), .err_parity(e_par)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checking, bus and adaptation tasks
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_len(input string what, input int lo, input int hi, input int got);
      tests_run++;
      if (got < lo || got > hi) begin
         failures++;
         $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(what, exp, reg_rdata);
   endtask

   // One adaptation; a filter start of F means not checked
   task automatic run(input logic exp_pass, input logic [3:0] exp_filt, input int lo, input int hi);
      @(posedge clk);
      adapt_start <= 1'b1;
      @(posedge clk);
      adapt_start <= 1'b0;
      #1;
      chk("busy and eq at start", 8'h10, {3'h0, adapt_busy, eq_setting});
      if (exp_filt !== 4'hF) chk("filter start", {4'h0, exp_filt}, {4'h0, filt});
      n = 1;
      while (adapt_done !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
         if (n == 13) begin
            eq_mid = eq_setting;
            filt_mid = filt;
         end
      end
      if (adapt_done !== 1'b1) begin
         chk("adapt_done", 8'h01, {7'h0, adapt_done});
         final_report();
      end
      chk_len("adapt length", lo, hi, n);
      chk("pass", {7'h0, exp_pass}, {7'h0, adapt_pass});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      {reg_wr, reg_rd, adapt_start, inject} = 6'h0;
      {reg_addr, reg_wdata} = 16'h0;
      lock_ok = 1'b1;
      period = 16'd8;
      failures = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      chk("port outputs", 8'h01, {2'b00, port_read_select, port_write_enable});
      foreach (rst_addr[i]) rd_chk("reset value", rst_addr[i], rst_val[i]);
      // Read data stand for one cycle only
      @(posedge clk);
      #1;
      chk("read data idle", 8'h00, reg_rdata);
      // Access kinds, reserved and unmapped places
      wr(ADDR_ERR_THOLD, 8'h5A);
      rd_chk("threshold", ADDR_ERR_THOLD, 8'h5A);
      wr(ADDR_ADAPT_CTL, 8'hFF);
      rd_chk("control", ADDR_ADAPT_CTL, 8'h7F);
      wr(ADDR_RSVD_A, 8'hFF);
      rd_chk("reserved", ADDR_RSVD_A, 8'h00);
      wr(8'h50, 8'hFF);
      rd_chk("unmapped", 8'h50, 8'h00);
      wr(ADDR_ADAPT_STATUS, 8'hFF);
      rd_chk("status", ADDR_ADAPT_STATUS, 8'h00);
      wr(ADDR_FILTER_LIMITS, 8'hFF);
      rd_chk("filter limits", ADDR_FILTER_LIMITS, 8'hEE);
      // Port select: read port in 5:4, write enables in 3:0
      for (int p = 0; p < 5; p++) begin
         wr(ADDR_PORT_SEL, (p == 4) ? 8'hEF : {2'b11, 2'(p), 4'(1 << p)});
         #1;
         chk("port outputs", (p == 4) ? 8'h2F : {2'b00, 2'(p), 4'(1 << p)},
             {2'b00, port_read_select, port_write_enable});
      end
      wr(ADDR_FILTER_LIMITS, 8'hC5);
      // Clean link: exact period, start point by order bit
      wr(ADDR_ADAPT_CTL, 8'h71);
      run(1'b1, 4'hC, 9, 9);
      rd_chk("status", ADDR_ADAPT_STATUS, 8'h40);
      wr(ADDR_ADAPT_CTL, 8'h79);
      run(1'b1, 4'h7, 9, 9);
      @(posedge clk);
      period <= 16'd5;
      run(1'b1, 4'h7, 6, 6);
      @(posedge clk);
      period <= 16'd8;
      // Lock lost: loop nesting seen at the second trial
      lock_ok <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_ADAPT_CTL, mode[k]);
         run(1'b0, fst[k], 20, 1999);
         chk("eq second trial", {4'h0, eqm[k]}, {4'h0, eq_mid});
         if (flm[k] !== 4'hF) chk("filter second trial", {4'h0, flm[k]}, {4'h0, filt_mid});
      end
      lock_ok <= 1'b1;
      // Error kinds: only selected kinds count, over the second half
      wr(ADDR_ERR_THOLD, 8'h03);
      for (int b = 0; b < 3; b++) begin
         wr(ADDR_ADAPT_CTL, {1'b0, 3'(1 << b), 4'h0});
         inject <= 3'(1 << ((b + 1) % 3));
         run(1'b1, 4'hF, 9, 9);
         inject <= 3'(1 << b);
         run(1'b0, 4'hF, 144, 146);
         chk("eq exhausted", 8'h0F, {4'h0, eq_setting});
      end
      wr(ADDR_ERR_THOLD, 8'h04);
      run(1'b1, 4'hF, 9, 9);
      wr(ADDR_ADAPT_CTL, 8'h70);
      inject <= 3'h7;
      run(1'b0, 4'hF, 144, 146);
      wr(ADDR_ADAPT_CTL, 8'h00);
      run(1'b1, 4'hF, 9, 9);
      // Two-step: early advance on errors, lock ignored
      wr(ADDR_ERR_THOLD, 8'hFF);
      wr(ADDR_ADAPT_CTL, 8'h74);
      run(1'b0, 4'hF, 80, 112);
      inject <= 3'h0;
      lock_ok <= 1'b0;
      run(1'b1, 4'hF, 9, 9);
      final_report();
   end

endmodule

`default_nettype wire

// file: verification/remote_serializer_model.sv
`timescale 1ns/1ps
`default_nettype none

module remote_serializer_model (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [2:0] inject,
   input  wire logic       lock_ok,
   output var  logic       link_lock,
   output var  logic       err_clock_pattern,
   output var  logic       err_control_channel_sequence,
   output var  logic       err_parity
);

   ////////////////////////////////////////////////////////////////////////////
   // Recovered lock and error pulses, one cycle behind the commands,
   // as a real receiver front end never reports in the same cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         link_lock <= 1'b0;
         {err_clock_pattern, err_control_channel_sequence, err_parity} <= 3'h0;
      end else begin
         link_lock <= lock_ok;
         {err_clock_pattern, err_control_channel_sequence, err_parity} <= inject;
      end
   end

endmodule

`default_nettype wire
